// File: src/status_event_command_core.sv
// status, event and common-command core of a remotely programmed instrument
//
// Summary of operation
// [R1] clear-status clears status byte, event status, summaries and error queue
// [R2] event enable mask is 8 bits, 0 to 255, query returns its value
// [R3] any enabled set event bit raises status byte bit 5
// [R4] event status reads only enabled occurred bits, as a decimal sum
// [R5] event status query clears the register after returning it
// [R6] operation-complete sets event bit 0 once earlier commands finish
// [R7] operation-complete query blocks new commands, then answers ascii 1
// [R8] wait command holds further commands until pending operations finish
// [R9] reset restores defaults, stops capture, flushes, keeps status registers
// [R10] service request enable is an 8-bit mask gating status byte bits
// [R11] status byte query returns enabled set bits without clearing them
// [R12] self-test query returns 0 on pass, 1 on any failure
// [R13] capture abort stops any capture at once and returns to block
// [R14] capture mode query reports block, streaming or sweeping; block after reset
// [R15] identification query returns maker, model, serial, firmware, no options
// [R16] commands and replies use network port 37001
// [R17] event bits stay latched until read or clear; summary recomputed each cycle
// [R18] commands run in order; one pending counter tracks outstanding operations
`timescale 1ns/1ps
module status_event_command_core #(
   // arbitrary neutral identity text, model without options
   parameter logic [127:0] ID_TEXT  = "mfr,mdl,0001,1.0",
   parameter logic [4:0]   ID_LEN   = 5'h10,
   parameter int           PEND_W   = 8
) (
   // clock and reset
   input  wire logic                      ref_clk_in,
   input  wire logic                      resetn_in,
   // decoded command stream
   input  wire logic                      cmd_valid_in,
   input  wire status_pkg::cmd_code_t     cmd_code_in,
   input  wire logic [7:0]                cmd_arg_in,
   output logic                           cmd_ready_out,
   // reply byte stream
   output logic                           resp_valid_out,
   output logic [7:0]                     resp_data_out,
   output logic                           resp_last_out,
   input  wire logic                      resp_ready_in,
   // event sources and other summaries
   input  wire logic [7:0]                event_in,
   input  wire logic                      err_queue_nonempty_in,
   input  wire logic                      ques_summary_in,
   input  wire logic                      oper_summary_in,
   output logic [7:0]                     status_byte_out,
   output logic                           clear_status_out,
   // instrument operations
   output logic                           op_start_out,
   output logic [7:0]                     op_arg_out,
   input  wire logic                      op_done_in,
   output logic                           settings_reset_out,
   output logic                           flush_out,
   // capture control
   output logic                           capture_abort_out,
   input  wire logic                      stream_start_in,
   input  wire logic                      sweep_start_in,
   input  wire logic                      capture_stop_in,
   output status_pkg::capture_mode_t      capture_mode_out,
   // self-test
   output logic                           selftest_start_out,
   input  wire logic                      selftest_done_in,
   input  wire logic                      selftest_fail_in,
   // network
   output logic [15:0]                    cmd_net_port_out
);
   import status_pkg::*;

   // --------------------------------------------------------------
   // state
   // --------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE, ST_WAIT_IDLE, ST_WAIT_OPCQ, ST_SELFTEST
   } core_fsm_t;

   typedef struct packed {
      core_fsm_t             state;
      logic [7:0]            evm;
      logic [7:0]            evs;
      logic [7:0]            srm;
      logic [7:0]            sum;
      capture_mode_t         mode;
      logic                  opc_armed;
      logic [RESP_BITS-1:0]  resp_buf;
      logic [RESP_LEN_W-1:0] resp_len;
      logic                  clear_status;
      logic                  settings_reset;
      logic                  flush;
      logic                  abort;
      logic                  op_start;
      logic [7:0]            op_arg;
      logic                  selftest_start;
      logic [15:0]           net_port;
   } core_state_t;

   localparam core_state_t CORE_RESET = '{
      state: ST_IDLE, evm: MASK_RESET, evs: MASK_RESET, srm: MASK_RESET, sum: MASK_RESET,
      mode: MODE_BLOCK, opc_armed: 1'b0, resp_buf: '0, resp_len: '0, clear_status: 1'b0,
      settings_reset: 1'b0, flush: 1'b0, abort: 1'b0, op_start: 1'b0, op_arg: 8'h00,
      selftest_start: 1'b0, net_port: CMD_NET_PORT};

   core_state_t r;
   core_state_t n;

   logic                  take;
   logic                  pend_idle;
   logic                  ops_idle;
   logic [7:0]            evs_visible;
   logic [7:0]            sum_base;
   logic [7:0]            sum_comb;
   logic [7:0]            fmt_value;
   logic [23:0]           dec_text;
   logic [1:0]            dec_len;
   logic [7:0]            evs_clr;
   logic [7:0]            opc_vec;
   logic                  opc_set;

   // left-aligns right-aligned text so the first character leaves first
   function automatic logic [RESP_BITS-1:0] align_text(input logic [RESP_BITS-1:0] t,
                                                       input logic [RESP_LEN_W-1:0] len);
      align_text = t << ((RESP_BYTES - int'(len)) * 8);
   endfunction

   // --------------------------------------------------------------
   // helpers
   // --------------------------------------------------------------
   pending_tracker #(
      .CNT_W     (PEND_W)
   ) i_pending_tracker (
      .ref_clk_in (ref_clk_in),
      .resetn_in  (resetn_in),
      .inc_in     (r.op_start),
      .dec_in     (op_done_in),
      .idle_out   (pend_idle),
      .count_out  ()
   );

   decimal_ascii i_decimal_ascii (
      .value_in (fmt_value),
      .text_out (dec_text),
      .len_out  (dec_len)
   );

   // --------------------------------------------------------------
   // handshake and summaries
   // --------------------------------------------------------------
   // [R7] blocked while waiting or replying
   assign cmd_ready_out = (r.state == ST_IDLE) && (r.resp_len == '0);
   assign take          = cmd_valid_in && cmd_ready_out;
   // a launch still in flight to the counter is not yet counted
   assign ops_idle      = pend_idle && !r.op_start;
   // [R4] only enabled bits are visible
   assign evs_visible   = r.evs & r.evm;

   always_comb
   begin
      sum_base               = '0;
      sum_base[SUM_ERR_BIT]  = err_queue_nonempty_in;
      sum_base[SUM_QUES_BIT] = ques_summary_in;
      sum_base[SUM_MAV_BIT]  = (r.resp_len != '0);
      // [R3] event summary bit
      sum_base[SUM_ESB_BIT]  = |evs_visible;
      sum_base[SUM_OPER_BIT] = oper_summary_in;
      sum_comb               = sum_base;
      sum_comb[SUM_MSS_BIT]  = |(sum_base & r.srm);
   end

   // value for the numeric replies
   always_comb
   begin
      case (cmd_code_in)
         CMD_EVM_Q: fmt_value = r.evm;
         CMD_EVS_Q: fmt_value = evs_visible;
         CMD_SRM_Q: fmt_value = r.srm;
         // [R11] gated by service request enable
         CMD_SUM_Q: fmt_value = sum_comb & r.srm;
         default:   fmt_value = 8'h00;
      endcase
      if (r.state == ST_WAIT_OPCQ)
         fmt_value = OPC_REPLY;
      else if (r.state == ST_SELFTEST)
         fmt_value = {7'h00, selftest_fail_in};
   end

   // --------------------------------------------------------------
   // next state
   // --------------------------------------------------------------
   always_comb
   begin
      n                = r;
      n.clear_status   = 1'b0;
      n.settings_reset = 1'b0;
      n.flush          = 1'b0;
      n.abort          = 1'b0;
      n.op_start       = 1'b0;
      n.selftest_start = 1'b0;
      // [R17] recomputed every cycle
      n.sum            = sum_comb;
      evs_clr          = '0;
      opc_set          = 1'b0;

      if (r.resp_len != '0 && resp_ready_in)
      begin
         n.resp_buf = r.resp_buf << 8;
         n.resp_len = r.resp_len - RESP_LEN_W'(1);
      end

      // [R6] bit 0 once all earlier operations are done
      if (r.opc_armed && ops_idle)
      begin
         opc_set     = 1'b1;
         n.opc_armed = 1'b0;
      end

      // [R14] block resumes when streaming or sweeping stops
      if (capture_stop_in)
         n.mode = MODE_BLOCK;
      else if (stream_start_in)
         n.mode = MODE_STREAMING;
      else if (sweep_start_in)
         n.mode = MODE_SWEEPING;

      case (r.state)
         ST_IDLE:
         begin
            // [R18] one command at a time, in arrival order
            if (take)
            begin
               case (cmd_code_in)
                  CMD_CLS:
                  begin
                     // [R1] clear status
                     evs_clr        = '1;
                     n.opc_armed    = 1'b0;
                     n.clear_status = 1'b1;
                  end
                  // [R2] full 8-bit mask, 0 to 255
                  CMD_EVM_SET: n.evm = cmd_arg_in;
                  // [R10] service request mask
                  CMD_SRM_SET: n.srm = cmd_arg_in;
                  CMD_EVM_Q, CMD_SRM_Q, CMD_SUM_Q:
                  begin
                     n.resp_buf = align_text(RESP_BITS'(dec_text), RESP_LEN_W'(dec_len));
                     n.resp_len = RESP_LEN_W'(dec_len);
                  end
                  CMD_EVS_Q:
                  begin
                     // [R5] destructive read
                     n.resp_buf = align_text(RESP_BITS'(dec_text), RESP_LEN_W'(dec_len));
                     n.resp_len = RESP_LEN_W'(dec_len);
                     evs_clr    = '1;
                  end
                  CMD_IDN_Q:
                  begin
                     // [R15] fixed identity text
                     n.resp_buf = align_text(ID_TEXT, ID_LEN);
                     n.resp_len = ID_LEN;
                  end
                  CMD_OPC:   n.opc_armed = 1'b1;
                  CMD_OPC_Q: n.state     = ST_WAIT_OPCQ;
                  CMD_RST:
                  begin
                     // [R9] masks and event bits untouched
                     n.settings_reset = 1'b1;
                     n.flush          = 1'b1;
                     n.mode           = MODE_BLOCK;
                  end
                  CMD_TST_Q:
                  begin
                     n.selftest_start = 1'b1;
                     n.state          = ST_SELFTEST;
                  end
                  // [R8] hold until operations are done
                  CMD_WAI: n.state = ST_WAIT_IDLE;
                  CMD_ABORT:
                  begin
                     // [R13] immediate stop, back to block
                     n.abort = 1'b1;
                     n.mode  = MODE_BLOCK;
                  end
                  CMD_MODE_Q:
                  begin
                     // [R14] mode text
                     case (r.mode)
                        MODE_STREAMING:
                        begin
                           n.resp_buf = align_text(RESP_BITS'(TXT_STREAMING), LEN_STREAMING);
                           n.resp_len = LEN_STREAMING;
                        end
                        MODE_SWEEPING:
                        begin
                           n.resp_buf = align_text(RESP_BITS'(TXT_SWEEPING), LEN_SWEEPING);
                           n.resp_len = LEN_SWEEPING;
                        end
                        default:
                        begin
                           n.resp_buf = align_text(RESP_BITS'(TXT_BLOCK), LEN_BLOCK);
                           n.resp_len = LEN_BLOCK;
                        end
                     endcase
                  end
                  CMD_OTHER:
                  begin
                     n.op_start = 1'b1;
                     n.op_arg   = cmd_arg_in;
                  end
                  default:
                  begin
                  end
               endcase
            end
         end
         ST_WAIT_IDLE:
         begin
            if (ops_idle)
               n.state = ST_IDLE;
         end
         ST_WAIT_OPCQ:
         begin
            // [R7] answer once idle
            if (ops_idle)
            begin
               n.resp_buf = align_text(RESP_BITS'(dec_text), RESP_LEN_W'(dec_len));
               n.resp_len = RESP_LEN_W'(dec_len);
               n.state    = ST_IDLE;
            end
         end
         ST_SELFTEST:
         begin
            // [R12] 0 pass, 1 fail
            if (selftest_done_in)
            begin
               n.resp_buf = align_text(RESP_BITS'(dec_text), RESP_LEN_W'(dec_len));
               n.resp_len = RESP_LEN_W'(dec_len);
               n.state    = ST_IDLE;
            end
         end
         default: n.state = ST_IDLE;
      endcase

      // [R17] new events win over a same-cycle clear
      opc_vec              = '0;
      opc_vec[EVS_OPC_BIT] = opc_set;
      n.evs                = (r.evs & ~evs_clr) | event_in | opc_vec;
   end

   always_ff @(posedge ref_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         r <= CORE_RESET;
      else
         r <= n;
   end

   // --------------------------------------------------------------
   // outputs
   // --------------------------------------------------------------
   assign resp_valid_out     = (r.resp_len != '0);
   assign resp_data_out      = r.resp_buf[RESP_BITS-1 -: 8];
   assign resp_last_out      = (r.resp_len == RESP_LEN_W'(1));
   assign status_byte_out    = r.sum;
   assign clear_status_out   = r.clear_status;
   assign op_start_out       = r.op_start;
   assign op_arg_out         = r.op_arg;
   assign settings_reset_out = r.settings_reset;
   assign flush_out          = r.flush;
   assign capture_abort_out  = r.abort;
   assign capture_mode_out   = r.mode;
   assign selftest_start_out = r.selftest_start;
   // [R16] command port number
   assign cmd_net_port_out   = r.net_port;

   // --------------------------------------------------------------
   // checks
   // --------------------------------------------------------------
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!resetn_in);

   sequence s_cmd(cmd_code_t c);
      take && cmd_code_in == c;
   endsequence

   sequence s_quiet;
      event_in == '0 && !(r.opc_armed && ops_idle);
   endsequence

   chk_esb_summary: assert property ( // [R3]
      status_byte_out[SUM_ESB_BIT] == $past(|evs_visible))
      else $error("event summary bit wrong");
   chk_evs_destructive: assert property ( // [R5]
      s_cmd(CMD_EVS_Q) and s_quiet |=> r.evs == '0 && resp_valid_out)
      else $error("event status not cleared by query");
   // a fresh completion request in the same cycle re-arms legally
   chk_opc_bit_set: assert property ( // [R6]
      r.opc_armed && ops_idle && !(take && cmd_code_in == CMD_OPC) |=> r.evs[EVS_OPC_BIT] && !r.opc_armed)
      else $error("operation complete bit not set");
   chk_wai_hold: assert property ( // [R8]
      s_cmd(CMD_WAI) ##1 !ops_idle |-> !cmd_ready_out)
      else $error("command accepted during wait");
   chk_opcq_reply: assert property ( // [R7]
      s_cmd(CMD_OPC_Q) ##1 ops_idle |=> resp_valid_out && resp_data_out == ASCII_ZERO + OPC_REPLY)
      else $error("operation complete query reply wrong");
   chk_rst_keeps_masks: assert property ( // [R9]
      s_cmd(CMD_RST) |=> $stable(r.evm) && $stable(r.srm) && flush_out && capture_mode_out == MODE_BLOCK)
      else $error("reset disturbed status or missed flush");
   chk_abort_block: assert property ( // [R13]
      s_cmd(CMD_ABORT) |=> capture_abort_out && capture_mode_out == MODE_BLOCK)
      else $error("abort did not return to block");
   chk_cls_clear: assert property ( // [R1]
      s_cmd(CMD_CLS) and s_quiet |=> r.evs == '0 && clear_status_out && !r.opc_armed)
      else $error("clear status incomplete");
   chk_event_sticky: assert property ( // [R17]
      (|event_in) |=> (r.evs & $past(event_in)) == $past(event_in))
      else $error("event lost");
   chk_evm_write: assert property ( // [R2]
      s_cmd(CMD_EVM_SET) |=> r.evm == $past(cmd_arg_in))
      else $error("event enable not written");
   chk_tst_reply: assert property ( // [R12]
      r.state == ST_SELFTEST && selftest_done_in |=> resp_data_out == ASCII_ZERO + 8'($past(selftest_fail_in)))
      else $error("self-test reply wrong");
endmodule

// File: src/status_pkg.sv
// shared constants and types of the status and event command core
package status_pkg;

   // --------------------------------------------------------------
   // mask registers and bit positions
   // --------------------------------------------------------------
   localparam int         MASK_W       = 8;
   localparam logic [7:0] MASK_RESET   = 8'h00;
   localparam int         EVS_OPC_BIT  = 0;
   localparam int         SUM_ERR_BIT  = 2;
   localparam int         SUM_QUES_BIT = 3;
   localparam int         SUM_MAV_BIT  = 4;
   localparam int         SUM_ESB_BIT  = 5;
   localparam int         SUM_MSS_BIT  = 6;
   localparam int         SUM_OPER_BIT = 7;

   // --------------------------------------------------------------
   // network and reply text
   // --------------------------------------------------------------
   // 37001 decimal
   localparam logic [15:0] CMD_NET_PORT  = 16'h9089;
   localparam int          RESP_BYTES    = 16;
   localparam int          RESP_BITS     = RESP_BYTES * 8;
   localparam int          RESP_LEN_W    = 5;
   localparam logic [7:0]  ASCII_ZERO    = 8'h30;
   localparam logic [7:0]  OPC_REPLY     = 8'h01;
   localparam logic [39:0] TXT_BLOCK     = "BLOCK";
   localparam logic [71:0] TXT_STREAMING = "STREAMING";
   localparam logic [63:0] TXT_SWEEPING  = "SWEEPING";
   localparam logic [4:0]  LEN_BLOCK     = 5'h05;
   localparam logic [4:0]  LEN_STREAMING = 5'h09;
   localparam logic [4:0]  LEN_SWEEPING  = 5'h08;

   // --------------------------------------------------------------
   // commands and capture modes
   // --------------------------------------------------------------
   typedef enum logic [3:0] {
      CMD_CLS, CMD_EVM_SET, CMD_EVM_Q, CMD_EVS_Q, CMD_IDN_Q, CMD_OPC, CMD_OPC_Q, CMD_RST,
      CMD_SRM_SET, CMD_SRM_Q, CMD_SUM_Q, CMD_TST_Q, CMD_WAI, CMD_ABORT, CMD_MODE_Q, CMD_OTHER
   } cmd_code_t;

   typedef enum logic [1:0] {
      MODE_BLOCK, MODE_STREAMING, MODE_SWEEPING
   } capture_mode_t;

endpackage

// File: src/pending_tracker.sv
// counter of launched instrument operations not yet finished
`timescale 1ns/1ps
module pending_tracker #(
   parameter int CNT_W = 8
) (
   // clock and reset
   input  wire logic             ref_clk_in,
   input  wire logic             resetn_in,
   // launch and finish pulses
   input  wire logic             inc_in,
   input  wire logic             dec_in,
   // state
   output logic                  idle_out,
   output logic [CNT_W-1:0]      count_out
);
   import status_pkg::*;

   typedef struct packed {
      logic [CNT_W-1:0] count;
   } pend_state_t;

   pend_state_t r;
   pend_state_t n;

   // --------------------------------------------------------------
   // counting
   // --------------------------------------------------------------
   always_comb
   begin
      n = r;
      // [R18] single pending count
      if (inc_in && !dec_in)
         n.count = r.count + CNT_W'(1);
      else if (dec_in && !inc_in && r.count != '0)
         n.count = r.count - CNT_W'(1);
   end

   always_ff @(posedge ref_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         r <= '0;
      else
         r <= n;
   end

   assign idle_out  = (r.count == '0);
   assign count_out = r.count;

   chk_pending_step: assert property (@(posedge ref_clk_in) disable iff (!resetn_in) // [R18]
      inc_in && !dec_in |=> count_out == $past(count_out) + CNT_W'(1))
      else $error("pending count did not step up");
endmodule

// File: src/decimal_ascii.sv
// 8-bit value to right-aligned decimal ascii digits
`timescale 1ns/1ps
module decimal_ascii (
   // value
   input  wire logic [7:0]  value_in,
   // text, first digit highest
   output logic [23:0]      text_out,
   output logic [1:0]       len_out
);
   import status_pkg::*;

   logic [7:0] hund;
   logic [7:0] tens;
   logic [7:0] ones;

   always_comb
   begin
      hund = ASCII_ZERO + 8'(value_in / 8'd100);
      tens = ASCII_ZERO + 8'((value_in / 8'd10) % 8'd10);
      ones = ASCII_ZERO + 8'(value_in % 8'd10);
      if (value_in >= 8'd100)
      begin
         text_out = {hund, tens, ones};
         len_out  = 2'h3;
      end
      else if (value_in >= 8'd10)
      begin
         text_out = {8'h00, tens, ones};
         len_out  = 2'h2;
      end
      else
      begin
         text_out = {16'h0000, ones};
         len_out  = 2'h1;
      end
   end
endmodule

// File: test/backend_model.sv
// back-end model finishing operations and self-tests
`timescale 1ns/1ps
module backend_model #(
   parameter int OP_DLY = 20
) (
   // clock
   input  wire logic ref_clk_in,
   // launches and test outcome
   input  wire logic op_start_in,
   input  wire logic selftest_start_in,
   input  wire logic fail_in,
   // answers
   output logic      op_done_out = 1'b0,
   output logic      selftest_done_out = 1'b0,
   output logic      selftest_fail_out = 1'b0
);
   int op_q[$];
   int t = 0;
   int st_cnt = 0;
   always @(posedge ref_clk_in)
   begin
      t++;
      op_done_out <= (op_q.size() > 0 && op_q[0] == t);
      if (op_q.size() > 0 && op_q[0] == t)
         void'(op_q.pop_front());
      if (op_start_in === 1'b1)
         op_q.push_back(t + OP_DLY);
      selftest_done_out <= (st_cnt == 1);
      // outcome flag is junk outside done
      selftest_fail_out <= (st_cnt == 1) ? fail_in : ~fail_in;
      if (st_cnt > 0)
         st_cnt--;
      if (selftest_start_in === 1'b1)
         st_cnt = 10;
   end
endmodule

// File: test/status_event_command_core_tb.sv
// self-checking bench of the status and event command core
`timescale 1ns/1ps
module status_event_command_core_tb;
   import status_pkg::*;
   logic          ref_clk_in = 1'b0;
   logic          resetn_in = 1'b0;
   logic          cmd_valid = 1'b0;
   cmd_code_t     cmd_code = CMD_OTHER;
   logic [7:0]    cmd_arg = 8'h00;
   logic [7:0]    ev = 8'h00;
   logic [2:0]    cap = 3'h0;
   logic          fail = 1'b0;
   logic          rr = 1'b1;
   logic          rdy, rv, rl, clr, op_st, op_dn, rst_p, fl_p, ab_p, st_st, st_dn, st_fl;
   logic [7:0]    rd, sb, op_arg;
   capture_mode_t mode;
   logic [15:0]   port;
   int            error_cnt = 0;
   int            cmp_count = 0;
   int            n_clr = 0;
   int            n_rst = 0;
   int            n_ab = 0;

   status_event_command_core i_status_event_command_core (
      .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .cmd_valid_in(cmd_valid), .cmd_code_in(cmd_code),
      .cmd_arg_in(cmd_arg), .cmd_ready_out(rdy), .resp_valid_out(rv), .resp_data_out(rd), .resp_last_out(rl),
      .resp_ready_in(rr), .event_in(ev), .err_queue_nonempty_in(1'b0), .ques_summary_in(1'b0),
      .oper_summary_in(1'b0), .status_byte_out(sb), .clear_status_out(clr), .op_start_out(op_st),
      .op_arg_out(op_arg), .op_done_in(op_dn), .settings_reset_out(rst_p), .flush_out(fl_p),
      .capture_abort_out(ab_p), .stream_start_in(cap[0]), .sweep_start_in(cap[1]),
      .capture_stop_in(cap[2]), .capture_mode_out(mode), .selftest_start_out(st_st),
      .selftest_done_in(st_dn), .selftest_fail_in(st_fl), .cmd_net_port_out(port));
   backend_model i_backend_model (.ref_clk_in(ref_clk_in), .op_start_in(op_st), .selftest_start_in(st_st),
      .fail_in(fail), .op_done_out(op_dn), .selftest_done_out(st_dn), .selftest_fail_out(st_fl));

   initial forever #2 ref_clk_in = ~ref_clk_in;
   always @(posedge ref_clk_in)
   begin
      n_clr += int'(clr);
      n_rst += int'(rst_p & fl_p);
      n_ab += int'(ab_p);
   end
   // -----------------------------------------------------------
   // tasks
   // -----------------------------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      cmp_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic send(input cmd_code_t c, input logic [7:0] a);
      int n;
      n = 0;
      @(posedge ref_clk_in);
      #1;
      cmd_valid = 1'b1;
      cmd_code = c;
      cmd_arg = a;
      while (rdy !== 1'b1 && n < 2000)
      begin
         @(posedge ref_clk_in);
         #1;
         n++;
      end
      @(posedge ref_clk_in);
      #1;
      cmd_valid = 1'b0;
   endtask
   task automatic query(input cmd_code_t c, input logic [127:0] exp, input int len);
      int i;
      int n;
      i = 0;
      n = 0;
      send(c, 8'h00);
      while (i < len && n < 2000)
      begin
         if (rv === 1'b1)
         begin
            chk(rd, exp[(len-1-i)*8 +: 8], "reply byte");
            chk(rl, i == len - 1, "last flag");
            // a byte only moves on when the host takes it
            i += int'(rr);
         end
         @(posedge ref_clk_in);
         #1;
         rr = ~rr;
         n++;
      end
      chk(16'(i), 16'(len), "reply length");
      chk(rv, 1'b0, "reply end");
   endtask
   task automatic pulse(input logic [7:0] e, input logic [2:0] c);
      ev = e;
      cap = c;
      @(posedge ref_clk_in);
      #1;
      ev = 8'h00;
      cap = 3'h0;
      repeat (3) @(posedge ref_clk_in);
      #1;
   endtask
   task automatic end_sim;
      $display("errors %0d comparisons %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // -----------------------------------------------------------
   // tests
   // -----------------------------------------------------------
   initial
   begin
      repeat (12) @(posedge ref_clk_in);
      #1;
      resetn_in = 1'b1;
      chk(mode, MODE_BLOCK, "reset mode");
      chk(port, 16'h9089, "net port");
      query(CMD_IDN_Q, "mfr,mdl,0001,1.0", 16);
      send(CMD_EVM_SET, 8'hc8);
      query(CMD_EVM_Q, "200", 3);
      send(CMD_SRM_SET, 8'h20);
      query(CMD_SRM_Q, "32", 2);
      pulse(8'h04, 3'h0);
      query(CMD_EVS_Q, "0", 1);
      pulse(8'h08, 3'h0);
      chk(sb[SUM_ESB_BIT], 1'b1, "event summary");
      query(CMD_SUM_Q, "32", 2);
      query(CMD_SUM_Q, "32", 2);
      query(CMD_EVS_Q, "8", 1);
      query(CMD_EVS_Q, "0", 1);
      send(CMD_EVM_SET, 8'h01);
      send(CMD_OTHER, 8'h5a);
      chk(op_arg, 8'h5a, "op arg");
      send(CMD_OPC, 8'h00);
      send(CMD_WAI, 8'h00);
      query(CMD_EVS_Q, "1", 1);
      send(CMD_OTHER, 8'h01);
      query(CMD_OPC_Q, "1", 1);
      fail = 1'b1;
      query(CMD_TST_Q, "1", 1);
      fail = 1'b0;
      query(CMD_TST_Q, "0", 1);
      pulse(8'h00, 3'h1);
      query(CMD_MODE_Q, "STREAMING", 9);
      pulse(8'h00, 3'h4);
      query(CMD_MODE_Q, "BLOCK", 5);
      pulse(8'h00, 3'h1);
      send(CMD_RST, 8'h00);
      query(CMD_MODE_Q, "BLOCK", 5);
      query(CMD_EVM_Q, "1", 1);
      chk(16'(n_rst), 16'h0001, "reset and flush");
      pulse(8'h00, 3'h2);
      query(CMD_MODE_Q, "SWEEPING", 8);
      send(CMD_ABORT, 8'h00);
      query(CMD_MODE_Q, "BLOCK", 5);
      chk(16'(n_ab), 16'h0001, "abort pulse");
      pulse(8'h01, 3'h0);
      send(CMD_CLS, 8'h00);
      query(CMD_EVS_Q, "0", 1);
      chk(16'(n_clr), 16'h0001, "clear pulse");
      end_sim;
   end
   initial
   begin
      #40000;
      error_cnt++;
      end_sim;
   end
endmodule
